// file: logic/rpss_pkg.sv
// Package with constants for the remappable pin select and slew block
package rpss_pkg;
   localparam int NUM_PORTS      = 2;
   localparam int PORT_WIDTH     = 16;
   localparam int NUM_BIDIR      = 8;
   localparam int NUM_INONLY     = 8;
   localparam int NUM_IN_FUNCS   = 8;
   localparam int NUM_OUT_FUNCS  = 8;
   localparam int SEL_WIDTH      = 8;
   localparam int OUT_SEL_WIDTH  = 6;
   localparam logic [7:0] SEL_RESET      = 8'h00;
   localparam logic [7:0] SEL_PIN_BASE   = 8'h01;
   localparam logic [5:0] OUT_SEL_NONE   = 6'h00;
   localparam logic [1:0] SLEW_FASTEST   = 2'h0;
   localparam logic [1:0] SLEW_X4        = 2'h1;
   localparam logic [1:0] SLEW_X8        = 2'h2;
   localparam logic [1:0] SLEW_X16       = 2'h3;
   localparam logic [15:0] SLEW_RESET    = 16'h0000;
   localparam logic [15:0] UNLOCK_KEY_A  = 16'h0055;
   localparam logic [15:0] UNLOCK_KEY_B  = 16'h00AA;
   localparam int UNLOCK_WINDOW_CYC = 4;
   typedef enum logic [1:0] {RPSS_LOCKED, RPSS_KEY1, RPSS_OPEN} rpss_lock_state_t;
endpackage : rpss_pkg

// file: logic/rpss_slew_port.sv
// Slew selection assembly for one I/O port
`timescale 1ns/10ps
`default_nettype none
module rpss_slew_port #(
   parameter int             WIDTH    = rpss_pkg::PORT_WIDTH,
   parameter logic [15:0]    SLEW_MSK = 16'hFFFF
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 slew_wr,
   input  wire logic [WIDTH-1:0]     slew_high_in,
   input  wire logic [WIDTH-1:0]     slew_low_in,
   output logic      [2*WIDTH-1:0]   slew_sel
);
   logic [WIDTH-1:0] slew_high_bit_reg;
   logic [WIDTH-1:0] slew_high_bit_next;
   logic [WIDTH-1:0] slew_low_bit_reg;
   logic [WIDTH-1:0] slew_low_bit_next;

   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("rpss_slew_port: WIDTH out of range");
   end

   always_comb begin
      slew_high_bit_next = slew_high_bit_reg;
      slew_low_bit_next  = slew_low_bit_reg;
      if (slew_wr) begin
         slew_high_bit_next = slew_high_in & SLEW_MSK[WIDTH-1:0];
         slew_low_bit_next  = slew_low_in & SLEW_MSK[WIDTH-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slew_high_bit_reg <= rpss_pkg::SLEW_RESET[WIDTH-1:0];
         slew_low_bit_reg  <= rpss_pkg::SLEW_RESET[WIDTH-1:0];
      end else begin
         slew_high_bit_reg <= slew_high_bit_next;
         slew_low_bit_reg  <= slew_low_bit_next;
      end
   end

   // High register gives msb, low register lsb; codes fastest, x4, x8, x16
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      assign slew_sel[2*i+1] = slew_high_bit_reg[i];
      assign slew_sel[2*i]   = slew_low_bit_reg[i];
   end

   property p_slew_follows;
      @(posedge sys_clk) disable iff (rst)
         slew_wr |=> slew_high_bit_reg == ($past(slew_high_in) & SLEW_MSK[WIDTH-1:0]);
   endproperty
   a_slew_follows: assert property (p_slew_follows)
      else $error("Slew high bits did not take the write");
endmodule : rpss_slew_port
`default_nettype wire

// file: logic/rpss_top.sv
// Remappable pin select fabric with priority resolution and slew selection
`timescale 1ns/10ps
`default_nettype none
module rpss_top #(
   parameter int NB   = rpss_pkg::NUM_BIDIR,
   parameter int NI   = rpss_pkg::NUM_INONLY,
   parameter int NIF  = rpss_pkg::NUM_IN_FUNCS,
   parameter int NOF  = rpss_pkg::NUM_OUT_FUNCS,
   parameter int PW   = rpss_pkg::PORT_WIDTH,
   parameter logic [15:0] SLEW_MSK_A = 16'hFFFF,
   parameter logic [15:0] SLEW_MSK_B = 16'h00FF
) (
   input  wire logic                                  sys_clk,
   input  wire logic                                  rst,
   input  wire logic [15:0]                           unlock_key,
   input  wire logic                                  unlock_key_wr,
   input  wire logic                                  relock,
   output logic                                       map_unlocked,
   input  wire logic                                  in_map_wr,
   input  wire logic [$clog2(NIF)-1:0]                in_map_idx,
   input  wire logic [rpss_pkg::SEL_WIDTH-1:0]        in_map_data,
   input  wire logic                                  out_map_wr,
   input  wire logic [$clog2(NB)-1:0]                 out_map_idx,
   input  wire logic [rpss_pkg::OUT_SEL_WIDTH-1:0]    out_map_data,
   input  wire logic [NB-1:0]                         bidir_remap_pin_i,
   input  wire logic [NI-1:0]                         input_only_remap_pin_i,
   output logic      [NIF-1:0]                        periph_in,
   input  wire logic [NOF-1:0]                        periph_out,
   input  wire logic [NOF-1:0]                        periph_out_en,
   input  wire logic [NB-1:0]                         port_out,
   input  wire logic [NB-1:0]                         port_oe,
   input  wire logic [NB-1:0]                         fixed_out,
   input  wire logic [NB-1:0]                         fixed_oe,
   input  wire logic [NB-1:0]                         fixed_active,
   input  wire logic [NB-1:0]                         analog_en,
   output logic      [NB-1:0]                         bidir_remap_pin_o,
   output logic      [NB-1:0]                         bidir_remap_pin_oe,
   output logic      [NB-1:0]                         remap_owns_pin,
   input  wire logic                                  slew_wr_a,
   input  wire logic [PW-1:0]                         slew_high_a,
   input  wire logic [PW-1:0]                         slew_low_a,
   input  wire logic                                  slew_wr_b,
   input  wire logic [PW-1:0]                         slew_high_b,
   input  wire logic [PW-1:0]                         slew_low_b,
   output logic      [2*PW-1:0]                       slew_sel_a,
   output logic      [2*PW-1:0]                       slew_sel_b
);
   localparam int NP = NB + NI;
   localparam int SW = rpss_pkg::SEL_WIDTH;
   localparam int OW = rpss_pkg::OUT_SEL_WIDTH;

   if (NP > 255 || NOF > 63 || NB < 2 || NIF < 2 || PW > 16) begin : g_bad_params
      $error("rpss_top: parameters out of range");
   end

   // Pin synchronisers
   logic [NP-1:0] pin_meta_reg;
   logic [NP-1:0] pin_sync_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {input_only_remap_pin_i, bidir_remap_pin_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Lock sequencer
   rpss_pkg::rpss_lock_state_t lock_reg;
   rpss_pkg::rpss_lock_state_t lock_next;
   logic [2:0] win_reg;
   logic [2:0] win_next;
   always_comb begin
      lock_next = lock_reg;
      win_next  = win_reg;
      unique case (lock_reg)
         rpss_pkg::RPSS_LOCKED: begin
            if (unlock_key_wr && unlock_key == rpss_pkg::UNLOCK_KEY_A) begin
               lock_next = rpss_pkg::RPSS_KEY1;
               win_next  = 3'(rpss_pkg::UNLOCK_WINDOW_CYC);
            end
         end
         rpss_pkg::RPSS_KEY1: begin
            win_next = win_reg - 3'h1;
            if (unlock_key_wr && unlock_key == rpss_pkg::UNLOCK_KEY_B)
               lock_next = rpss_pkg::RPSS_OPEN;
            else if (unlock_key_wr || win_reg == 3'h1)
               lock_next = rpss_pkg::RPSS_LOCKED;
         end
         rpss_pkg::RPSS_OPEN: begin
            if (relock)
               lock_next = rpss_pkg::RPSS_LOCKED;
         end
         default: lock_next = rpss_pkg::RPSS_LOCKED;
      endcase
   end

   logic map_ok;
   assign map_ok = lock_reg == rpss_pkg::RPSS_OPEN;

   // Input map per function, output map per bidirectional pin
   logic [SW-1:0] in_sel_reg  [NIF];
   logic [SW-1:0] in_sel_next [NIF];
   logic [OW-1:0] out_sel_reg  [NB];
   logic [OW-1:0] out_sel_next [NB];
   always_comb begin
      for (int f = 0; f < NIF; f++) begin
         in_sel_next[f] = in_sel_reg[f];
         if (map_ok && in_map_wr && in_map_idx == f[$clog2(NIF)-1:0])
            in_sel_next[f] = in_map_data;
      end
      for (int p = 0; p < NB; p++) begin
         out_sel_next[p] = out_sel_reg[p];
         if (map_ok && out_map_wr && out_map_idx == p[$clog2(NB)-1:0])
            out_sel_next[p] = out_map_data;
      end
   end

   // Pin routing; selection 0 ties inputs low and leaves outputs to the port or fixed driver
   logic [NIF-1:0] periph_in_next;
   logic [NB-1:0]  pin_o_next;
   logic [NB-1:0]  pin_oe_next;
   logic [NB-1:0]  own_next;
   always_comb begin
      int unsigned k;
      k = 0;
      for (int f = 0; f < NIF; f++) begin
         k = 32'(in_sel_reg[f]) - 32'(rpss_pkg::SEL_PIN_BASE);
         periph_in_next[f] = 1'b0;
         if (in_sel_reg[f] >= rpss_pkg::SEL_PIN_BASE && k < NP && !(k < NB && analog_en[k]))
            periph_in_next[f] = pin_sync_reg[k];
      end
      for (int p = 0; p < NB; p++) begin
         k = 32'(out_sel_reg[p]) - 32'(rpss_pkg::SEL_PIN_BASE);
         own_next[p]    = 1'b0;
         pin_o_next[p]  = port_out[p];
         pin_oe_next[p] = port_oe[p];
         if (fixed_active[p]) begin
            pin_o_next[p]  = fixed_out[p];
            pin_oe_next[p] = fixed_oe[p];
         end
         if (out_sel_reg[p] != rpss_pkg::OUT_SEL_NONE && k < NOF && periph_out_en[k]) begin
            own_next[p]    = 1'b1;
            pin_o_next[p]  = periph_out[k];
            pin_oe_next[p] = 1'b1;
         end
         if (analog_en[p]) begin
            own_next[p]    = 1'b0;
            pin_o_next[p]  = 1'b0;
            pin_oe_next[p] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_reg           <= rpss_pkg::RPSS_LOCKED;
         win_reg            <= '0;
         map_unlocked       <= 1'b0;
         periph_in          <= '0;
         bidir_remap_pin_o  <= '0;
         bidir_remap_pin_oe <= '0;
         remap_owns_pin     <= '0;
         for (int f = 0; f < NIF; f++) in_sel_reg[f] <= rpss_pkg::SEL_RESET;
         for (int p = 0; p < NB; p++) out_sel_reg[p] <= rpss_pkg::OUT_SEL_NONE;
      end else begin
         lock_reg           <= lock_next;
         win_reg            <= win_next;
         map_unlocked       <= lock_next == rpss_pkg::RPSS_OPEN;
         periph_in          <= periph_in_next;
         bidir_remap_pin_o  <= pin_o_next;
         bidir_remap_pin_oe <= pin_oe_next;
         remap_owns_pin     <= own_next;
         in_sel_reg         <= in_sel_next;
         out_sel_reg        <= out_sel_next;
      end
   end

   rpss_slew_port #(.WIDTH(PW), .SLEW_MSK(SLEW_MSK_A)) u_slew_a (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .slew_wr      (slew_wr_a),
      .slew_high_in (slew_high_a),
      .slew_low_in  (slew_low_a),
      .slew_sel     (slew_sel_a)
   );
   rpss_slew_port #(.WIDTH(PW), .SLEW_MSK(SLEW_MSK_B)) u_slew_b (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .slew_wr      (slew_wr_b),
      .slew_high_in (slew_high_b),
      .slew_low_in  (slew_low_b),
      .slew_sel     (slew_sel_b)
   );

   sequence s_key_a;
      unlock_key_wr && unlock_key == rpss_pkg::UNLOCK_KEY_A && lock_reg == rpss_pkg::RPSS_LOCKED;
   endsequence
   sequence s_key_b;
      unlock_key_wr && unlock_key == rpss_pkg::UNLOCK_KEY_B;
   endsequence

   property p_unlock_seq;
      @(posedge sys_clk) disable iff (rst) s_key_a ##1 s_key_b |=> map_unlocked;
   endproperty
   a_unlock_seq: assert property (p_unlock_seq) else $error("Key pair did not unlock");

   property p_locked_hold;
      @(posedge sys_clk) disable iff (rst) !map_ok && in_map_wr |=> $stable(in_sel_reg[0]);
   endproperty
   a_locked_hold: assert property (p_locked_hold)
      else $error("Input map changed while locked");

   property p_analog_wins;
      @(posedge sys_clk) disable iff (rst) analog_en[0] |=> !bidir_remap_pin_oe[0] && !remap_owns_pin[0];
   endproperty
   a_analog_wins: assert property (p_analog_wins) else $error("Analog pin still driven");

   property p_remap_wins;
      @(posedge sys_clk) disable iff (rst)
         !analog_en[0] && out_sel_reg[0] == 6'h01 && periph_out_en[0]
         |=> bidir_remap_pin_oe[0] && bidir_remap_pin_o[0] == $past(periph_out[0]);
   endproperty
   a_remap_wins: assert property (p_remap_wins)
      else $error("Remapped output lost the pin");

   property p_unmapped_quiet;
      @(posedge sys_clk) disable iff (rst) in_sel_reg[0] == rpss_pkg::SEL_RESET |=> !periph_in[0];
   endproperty
   a_unmapped_quiet: assert property (p_unmapped_quiet)
      else $error("Unmapped input not tied low");

   property p_invalid_quiet;
      @(posedge sys_clk) disable iff (rst) in_sel_reg[1] > 8'(NP) |=> !periph_in[1];
   endproperty
   a_invalid_quiet: assert property (p_invalid_quiet)
      else $error("Invalid selection not tied low");

   property p_fixed_default;
      @(posedge sys_clk) disable iff (rst)
         fixed_active[NB-1] && !analog_en[NB-1] && out_sel_reg[NB-1] == rpss_pkg::OUT_SEL_NONE
         |=> bidir_remap_pin_oe[NB-1] == $past(fixed_oe[NB-1]);
   endproperty
   a_fixed_default: assert property (p_fixed_default)
      else $error("Fixed peripheral lost its pin");

   property p_in_route;
      @(posedge sys_clk) disable iff (rst)
         in_sel_reg[0] == 8'(NB + 1) |=> periph_in[0] == $past(pin_sync_reg[NB]);
   endproperty
   a_in_route: assert property (p_in_route) else $error("Input-only pin not routed");
endmodule : rpss_top
`default_nettype wire

// file: verif/rpss_far_model.sv
// Far-side model of the remappable pins: resolves each pin level from both drivers
`timescale 1ns/10ps
`default_nettype none
module rpss_far_model #(
   parameter int NB = 8
) (
   input  wire logic [NB-1:0] pin_o,
   input  wire logic [NB-1:0] pin_oe,
   input  wire logic [NB-1:0] ext_level,
   output logic      [NB-1:0] pin_i
);
   // Device drive wins while its enable is high, else the external level shows
   always_comb begin
      for (int i = 0; i < NB; i++) begin
         pin_i[i] = pin_oe[i] ? pin_o[i] : ext_level[i];
      end
   end
endmodule : rpss_far_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the remappable pin select and slew block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   typedef struct packed {logic [2:0] idx; logic [7:0] sel; logic exp;} rpss_row_t;
   logic        sys_clk, rst, unlock_key_wr, relock, in_map_wr, out_map_wr, map_unlocked;
   logic [15:0] unlock_key, slew_high_a, slew_low_a, slew_high_b, slew_low_b;
   logic [2:0]  in_map_idx, out_map_idx;
   logic [7:0]  in_map_data, pin_i, ext_b, ext_i, periph_in, periph_out, periph_out_en;
   logic [7:0]  port_out, port_oe, fixed_out, fixed_oe, fixed_active, analog_en;
   logic [7:0]  pin_o, pin_oe, owns;
   logic [5:0]  out_map_data;
   logic        slew_wr_a, slew_wr_b;
   logic [31:0] slew_sel_a, slew_sel_b;
   int          n_mismatch = 0, n_compared = 0, cyc = 0;
   rpss_row_t   rows [11] = '{
      '{3'h0, 8'h09, 1'b1}, '{3'h0, 8'h11, 1'b0}, '{3'h1, 8'h01, 1'b1}, '{3'h2, 8'h02, 1'b0},
      '{3'h3, 8'h07, 1'b0}, '{3'h4, 8'h08, 1'b1}, '{3'h5, 8'h09, 1'b1}, '{3'h6, 8'h0A, 1'b0},
      '{3'h7, 8'h10, 1'b1}, '{3'h7, 8'h00, 1'b0}, '{3'h1, 8'hFF, 1'b0}};

   rpss_top i_dut (.sys_clk(sys_clk), .rst(rst), .unlock_key(unlock_key),
      .unlock_key_wr(unlock_key_wr), .relock(relock), .map_unlocked(map_unlocked),
      .in_map_wr(in_map_wr), .in_map_idx(in_map_idx), .in_map_data(in_map_data),
      .out_map_wr(out_map_wr), .out_map_idx(out_map_idx), .out_map_data(out_map_data),
      .bidir_remap_pin_i(pin_i), .input_only_remap_pin_i(ext_i), .periph_in(periph_in),
      .periph_out(periph_out), .periph_out_en(periph_out_en), .port_out(port_out),
      .port_oe(port_oe), .fixed_out(fixed_out), .fixed_oe(fixed_oe),
      .fixed_active(fixed_active), .analog_en(analog_en), .bidir_remap_pin_o(pin_o),
      .bidir_remap_pin_oe(pin_oe), .remap_owns_pin(owns), .slew_wr_a(slew_wr_a),
      .slew_high_a(slew_high_a), .slew_low_a(slew_low_a), .slew_wr_b(slew_wr_b),
      .slew_high_b(slew_high_b), .slew_low_b(slew_low_b), .slew_sel_a(slew_sel_a),
      .slew_sel_b(slew_sel_b));

   rpss_far_model i_far (.pin_o(pin_o), .pin_oe(pin_oe), .ext_level(ext_b), .pin_i(pin_i));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle

   task automatic wr_key(input logic [15:0] k);
      @(negedge sys_clk);
      unlock_key    = k;
      unlock_key_wr = 1'b1;
      @(negedge sys_clk);
      unlock_key_wr = 1'b0;
   endtask : wr_key

   task automatic wr_in(input logic [2:0] idx, input logic [7:0] sel);
      @(negedge sys_clk);
      in_map_idx  = idx;
      in_map_data = sel;
      in_map_wr   = 1'b1;
      @(negedge sys_clk);
      in_map_wr   = 1'b0;
   endtask : wr_in

   task automatic wr_out(input logic [2:0] idx, input logic [5:0] sel);
      @(negedge sys_clk);
      out_map_idx  = idx;
      out_map_data = sel;
      out_map_wr   = 1'b1;
      @(negedge sys_clk);
      out_map_wr   = 1'b0;
   endtask : wr_out

   initial begin
      rst = 1'b1;
      {unlock_key_wr, relock, in_map_wr, out_map_wr, slew_wr_a, slew_wr_b} = 6'h00;
      {unlock_key, slew_high_a, slew_low_a, slew_high_b, slew_low_b} = 80'h0;
      {in_map_idx, out_map_idx, in_map_data, out_map_data} = 20'h0_0000;
      {periph_out, periph_out_en, port_out, port_oe} = 32'h0000_0000;
      {fixed_out, fixed_oe, fixed_active, analog_en} = 32'h0000_0000;
      ext_b = 8'hA5;
      ext_i = 8'hBD;
      idle(8);
      rst = 1'b0;
      idle(1);
      chk("map_unlocked", 32'(map_unlocked), 32'h0);
      chk("periph_in", 32'(periph_in), 32'h0);
      chk("pin_oe", 32'(pin_oe), 32'h0);
      chk("slew_sel_a", slew_sel_a, 32'h0);
      chk("slew_sel_b", slew_sel_b, 32'h0);
      $display("test reset done");
      wr_in(3'h0, 8'h01);
      idle(4);
      chk("periph_in locked", 32'(periph_in[0]), 32'h0);
      wr_key(rpss_pkg::UNLOCK_KEY_A);
      wr_key(16'h1234);
      wr_key(rpss_pkg::UNLOCK_KEY_B);
      idle(1);
      chk("map_unlocked bad order", 32'(map_unlocked), 32'h0);
      wr_key(rpss_pkg::UNLOCK_KEY_A);
      idle(6);
      wr_key(rpss_pkg::UNLOCK_KEY_B);
      idle(1);
      chk("map_unlocked late key", 32'(map_unlocked), 32'h0);
      wr_key(rpss_pkg::UNLOCK_KEY_A);
      wr_key(rpss_pkg::UNLOCK_KEY_B);
      idle(1);
      chk("map_unlocked", 32'(map_unlocked), 32'h1);
      $display("test lock done");
      foreach (rows[r]) begin
         wr_in(rows[r].idx, rows[r].sel);
         idle(4);
         chk("periph_in", 32'(periph_in[rows[r].idx]), 32'(rows[r].exp));
      end
      $display("test input table done");
      analog_en = 8'h01;
      wr_in(3'h0, 8'h01);
      idle(4);
      chk("periph_in analog", 32'(periph_in[0]), 32'h0);
      periph_out    = 8'h05;
      periph_out_en = 8'hFF;
      fixed_active  = 8'h85;
      fixed_out     = 8'h04;
      fixed_oe      = 8'h85;
      port_out      = 8'h0B;
      port_oe       = 8'h0F;
      analog_en     = 8'h02;
      wr_out(3'h0, 6'h01);
      wr_out(3'h1, 6'h03);
      wr_out(3'h4, 6'h03);
      idle(3);
      chk("pin_oe", 32'(pin_oe), 32'h9D);
      chk("pin_o", 32'(pin_o & pin_oe), 32'h1D);
      chk("owns", 32'(owns), 32'h11);
      chk("periph_in kept", 32'(periph_in[0]), 32'h1);
      $display("test output priority done");
      @(negedge sys_clk);
      slew_high_a = 16'h000C;
      slew_low_a  = 16'h000A;
      slew_high_b = 16'hFFFF;
      slew_low_b  = 16'hFFFF;
      slew_wr_a   = 1'b1;
      slew_wr_b   = 1'b1;
      @(negedge sys_clk);
      {slew_wr_a, slew_wr_b} = 2'h0;
      idle(1);
      chk("slew_sel_a", slew_sel_a, {24'h0, rpss_pkg::SLEW_X16, rpss_pkg::SLEW_X8,
                                     rpss_pkg::SLEW_X4, rpss_pkg::SLEW_FASTEST});
      chk("slew_sel_b", slew_sel_b, 32'h0000_FFFF);
      $display("test slew done");
      @(negedge sys_clk);
      relock = 1'b1;
      @(negedge sys_clk);
      relock = 1'b0;
      idle(1);
      chk("map_unlocked relock", 32'(map_unlocked), 32'h0);
      wr_out(3'h0, 6'h00);
      idle(3);
      chk("owns after relock", 32'(owns), 32'h11);
      @(negedge sys_clk);
      unlock_key    = rpss_pkg::UNLOCK_KEY_A;
      unlock_key_wr = 1'b1;
      @(negedge sys_clk);
      unlock_key    = rpss_pkg::UNLOCK_KEY_B;
      @(negedge sys_clk);
      unlock_key_wr = 1'b0;
      idle(1);
      chk("map_unlocked back to back", 32'(map_unlocked), 32'h1);
      wr_out(3'h0, 6'h00);
      idle(3);
      chk("owns after unlock", 32'(owns), 32'h10);
      $display("test relock done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
